// File: include/drs_pkg.sv
// constants for the dither ram access port and output signature block
`default_nettype none
package drs_pkg;
    // ****************************************************************
    // register map (byte addresses)
    // ****************************************************************
    localparam logic [3:0]  OFS_CTRL_POINTER  = 4'h0;
    localparam logic [3:0]  OFS_DATA_PORT     = 4'h4;
    localparam logic [3:0]  OFS_SIGNATURE     = 4'h8;
    // ****************************************************************
    // fields
    // ****************************************************************
    localparam int          PTR_LSB           = 0;
    localparam int          PTR_W             = 6;
    localparam int          EN_LSB            = 6;
    localparam int          EN_W              = 2;
    localparam logic [1:0]  EN_ALL            = 2'h3;
    localparam int          SIG_W             = 24;
    localparam int          FRAME_W           = 8;
    localparam int          RAM_DEPTH         = 64;
    localparam logic [31:0] CTRL_RESET        = 32'h0000_0000;
    localparam logic [23:0] SIG_SEED          = 24'hff_ffff;
    localparam logic [23:0] SIG_POLY          = 24'h86_4cfb;
    localparam logic [1:0]  RESP_OKAY         = 2'h0;
    localparam logic [1:0]  RESP_SLVERR       = 2'h2;
endpackage
`default_nettype wire

// File: verilog/drs_dither_ram_port.sv
// dither ram access port with per-frame output signature, axi4-lite slave
`timescale 1ns/1ps
`default_nettype none
module drs_dither_ram_port (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic [3:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [3:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic [23:0] pixelData,
    input  wire logic        pixelValid,
    input  wire logic        frameEnd,
    output logic             ramPowerDown
);
    // ****************************************************************
    // state
    // ****************************************************************
    logic [31:0]                 ctrl_q;
    logic [31:0]                 ram_q [drs_pkg::RAM_DEPTH];
    logic [23:0]                 crc_q;
    logic [23:0]                 sig_q;
    logic [7:0]                  frame_q;
    logic [7:0]                  sigFrame_q;
    logic [3:0]                  awAddr_q;
    logic                        awHave_q;
    logic [31:0]                 wData_q;
    logic [3:0]                  wStrb_q;
    logic                        wHave_q;
    logic                        enabled;
    logic [5:0]                  ptr;
    logic                        doWrite;
    logic                        doRead;
    logic                        wrData;
    logic                        rdData;
    logic [23:0]                 crc_d;

    assign ptr          = ctrl_q[drs_pkg::PTR_LSB +: drs_pkg::PTR_W];
    assign enabled      = ctrl_q[drs_pkg::EN_LSB +: drs_pkg::EN_W] == drs_pkg::EN_ALL;
    assign ramPowerDown = !enabled;

    // ****************************************************************
    // axi4-lite handshakes
    // ****************************************************************
    // one outstanding write: address and data latched in either order
    assign awready = !awHave_q && !bvalid;
    assign wready  = !wHave_q && !bvalid;
    assign doWrite = awHave_q && wHave_q && !bvalid;
    assign arready = !rvalid;
    assign doRead  = arvalid && arready;
    assign wrData  = doWrite && awAddr_q == drs_pkg::OFS_DATA_PORT && enabled;
    assign rdData  = doRead && araddr == drs_pkg::OFS_DATA_PORT && enabled;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            awHave_q <= 1'b0;
            awAddr_q <= 4'h0;
        end else if (awvalid && awready) begin
            awHave_q <= 1'b1;
            awAddr_q <= awaddr;
        end else if (doWrite) begin
            awHave_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            wHave_q <= 1'b0;
            wData_q <= 32'h0;
            wStrb_q <= 4'h0;
        end else if (wvalid && wready) begin
            wHave_q <= 1'b1;
            wData_q <= wdata;
            wStrb_q <= wstrb;
        end else if (doWrite) begin
            wHave_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            bvalid <= 1'b0;
            bresp  <= drs_pkg::RESP_OKAY;
        end else if (doWrite) begin
            bvalid <= 1'b1;
            // disabled ram refuses the data port; unmapped addresses also err
            if ((awAddr_q == drs_pkg::OFS_DATA_PORT && !enabled) ||
                (awAddr_q != drs_pkg::OFS_CTRL_POINTER && awAddr_q != drs_pkg::OFS_DATA_PORT &&
                 awAddr_q != drs_pkg::OFS_SIGNATURE)) begin
                bresp <= drs_pkg::RESP_SLVERR;
            end else begin
                bresp <= drs_pkg::RESP_OKAY;
            end
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // control / pointer register
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ctrl_q <= drs_pkg::CTRL_RESET;
        end else if (doWrite && awAddr_q == drs_pkg::OFS_CTRL_POINTER) begin
            for (int b = 0; b < 4; b++) begin
                if (wStrb_q[b]) begin
                    ctrl_q[b*8 +: 8] <= wData_q[b*8 +: 8];
                end
            end
        end else if (wrData || rdData) begin
            // pointer wraps at 63; only one of read and write may advance per cycle
            ctrl_q[drs_pkg::PTR_LSB +: drs_pkg::PTR_W] <= ptr + 6'h1;
        end
    end

    // ****************************************************************
    // dither ram, flip-flop storage
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        if (wrData) begin
            for (int b = 0; b < 4; b++) begin
                if (wStrb_q[b]) begin
                    ram_q[ptr][b*8 +: 8] <= wData_q[b*8 +: 8];
                end
            end
        end
    end

    // a simultaneous read and write to the data port use the same pointer, which advances once;
    // read is stalled by arready only when rvalid is busy, so the host should serialise
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0;
            rresp  <= drs_pkg::RESP_OKAY;
        end else if (doRead) begin
            rvalid <= 1'b1;
            rresp  <= drs_pkg::RESP_OKAY;
            unique case (araddr)
                drs_pkg::OFS_CTRL_POINTER: rdata <= ctrl_q;
                drs_pkg::OFS_DATA_PORT: begin
                    rdata <= enabled ? ram_q[ptr] : 32'h0;
                    if (!enabled) begin
                        rresp <= drs_pkg::RESP_SLVERR;
                    end
                end
                drs_pkg::OFS_SIGNATURE: rdata <= {sigFrame_q, sig_q};
                default: begin
                    rdata <= 32'h0;
                    rresp <= drs_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // output signature
    // ****************************************************************
    // crc-24, one pixel per cycle folded msb first
    always_comb begin
        crc_d = crc_q;
        for (int i = drs_pkg::SIG_W - 1; i >= 0; i--) begin
            if (crc_d[23] ^ pixelData[i]) begin
                crc_d = {crc_d[22:0], 1'b0} ^ drs_pkg::SIG_POLY;
            end else begin
                crc_d = {crc_d[22:0], 1'b0};
            end
        end
    end

    // signature register is never written by software
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            crc_q      <= drs_pkg::SIG_SEED;
            sig_q      <= 24'h0;
            frame_q    <= 8'h0;
            sigFrame_q <= 8'h0;
        end else if (frameEnd) begin
            // a pixel in the frame-end cycle belongs to the closing frame
            sig_q      <= pixelValid ? crc_d : crc_q;
            sigFrame_q <= frame_q;
            frame_q    <= frame_q + 8'h1;
            crc_q      <= drs_pkg::SIG_SEED;
        end else if (pixelValid) begin
            crc_q <= crc_d;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    a_disabled_no_advance: assert property (@(posedge sys_clk) disable iff (!rstn)
        (!enabled && !(doWrite && awAddr_q == drs_pkg::OFS_CTRL_POINTER)) |=> $stable(ptr))
        else $error("pointer moved while ram disabled");
    a_pointer_advance: assert property (@(posedge sys_clk) disable iff (!rstn)
        (wrData || rdData) |=> ptr == $past(ptr) + 6'h1)
        else $error("pointer did not advance on data access");
    a_ram_readback: assert property (@(posedge sys_clk) disable iff (!rstn)
        rdData |=> rdata == $past(ram_q[ptr]))
        else $error("data port returned wrong word");
    a_sig_stable_mid: assert property (@(posedge sys_clk) disable iff (!rstn)
        !frameEnd |=> $stable(sig_q) && $stable(sigFrame_q))
        else $error("signature changed outside frame end");
    a_frame_index_step: assert property (@(posedge sys_clk) disable iff (!rstn)
        frameEnd |=> sigFrame_q == frame_q - 8'h1)
        else $error("frame index not latched with signature");
    a_crc_restart: assert property (@(posedge sys_clk) disable iff (!rstn)
        frameEnd |=> crc_q == drs_pkg::SIG_SEED)
        else $error("crc did not restart at frame end");
    a_write_pointer: assert property (@(posedge sys_clk) disable iff (!rstn)
        (doWrite && awAddr_q == drs_pkg::OFS_CTRL_POINTER && wStrb_q[0])
        |=> ptr == $past(wData_q[5:0]))
        else $error("pointer write not taken");
    a_powerdown_read: assert property (@(posedge sys_clk) disable iff (!rstn)
        (doRead && araddr == drs_pkg::OFS_DATA_PORT && ramPowerDown)
        |=> rresp == drs_pkg::RESP_SLVERR && rdata == 32'h0)
        else $error("powered-down ram answered a read");
    a_powerdown_write: assert property (@(posedge sys_clk) disable iff (!rstn)
        (doWrite && awAddr_q == drs_pkg::OFS_DATA_PORT && ramPowerDown)
        |=> bresp == drs_pkg::RESP_SLVERR && $stable(ptr))
        else $error("powered-down ram took a write");
endmodule
`default_nettype wire

// File: test/drs_testbench.sv
// self-checking bench for the dither ram access port and output signature
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic sys_clk = 1'b0, rstn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, pixelValid = 1'b0, frameEnd = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
    logic [31:0] wdata = 32'h0;
    logic [23:0] pixelData = 24'h0;
    logic awready, wready, bvalid, arready, rvalid, ramPowerDown;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int nErrors = 0, checks = 0;
    drs_dither_ram_port drs_dither_ram_port_i (.sys_clk(sys_clk), .rstn(rstn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .pixelData(pixelData), .pixelValid(pixelValid),
        .frameEnd(frameEnd), .ramPowerDown(ramPowerDown));
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    // ****************************************************************
    // report and compare
    // ****************************************************************
    task automatic results;
        $display("checks %0d mismatches %0d", checks, nErrors);
        if (nErrors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chkv(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            nErrors++;
            $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic chkr(input logic [1:0] got, input logic [1:0] exp);
        checks++;
        if (got !== exp) begin
            nErrors++;
            $display("unexpected at %0t: response %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic hang;
        nErrors++;
        $display("unexpected at %0t: no answer from the slave", $time);
        results();
    endtask
    // ****************************************************************
    // axi4-lite master; each task starts one edge after the last ended
    // ****************************************************************
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        int k;
        @(posedge sys_clk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge sys_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (k == 50) hang();
        chkr(bresp, er);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        int k;
        @(posedge sys_clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge sys_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (k == 50) hang();
        chkr(rresp, er);
        chkv(rdata, ed);
        rready <= 1'b0;
    endtask
    // crc-24, msb first, one pixel word folded in
    function automatic logic [23:0] crcStep(input logic [23:0] c, input logic [23:0] d);
        logic fb;
        for (int i = 23; i >= 0; i--) begin
            fb = c[23] ^ d[i];
            c = {c[22:0], 1'b0} ^ (fb ? drs_pkg::SIG_POLY : 24'h0);
        end
        return c;
    endfunction
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic testGate;
        logic [31:0] g [3] = '{32'h45, 32'h85, 32'h05};
        rd(drs_pkg::OFS_CTRL_POINTER, drs_pkg::CTRL_RESET, drs_pkg::RESP_OKAY);
        chkv({31'h0, ramPowerDown}, 32'h1);
        foreach (g[i]) begin
            wr(drs_pkg::OFS_CTRL_POINTER, g[i], drs_pkg::RESP_OKAY);
            chkv({31'h0, ramPowerDown}, 32'h1);
            wr(drs_pkg::OFS_DATA_PORT, 32'h1111_2222, drs_pkg::RESP_SLVERR);
            rd(drs_pkg::OFS_DATA_PORT, 32'h0, drs_pkg::RESP_SLVERR);
        end
        rd(drs_pkg::OFS_CTRL_POINTER, 32'h05, drs_pkg::RESP_OKAY);
        rd(4'hc, 32'h0, drs_pkg::RESP_SLVERR);
        $display("gate test done");
    endtask
    task automatic testRam;
        logic [31:0] w [3] = '{32'ha5a5_0001, 32'h5a5a_0002, 32'hdead_0003};
        wr(drs_pkg::OFS_CTRL_POINTER, 32'hfe, drs_pkg::RESP_OKAY);
        chkv({31'h0, ramPowerDown}, 32'h0);
        foreach (w[i]) wr(drs_pkg::OFS_DATA_PORT, w[i], drs_pkg::RESP_OKAY);
        rd(drs_pkg::OFS_CTRL_POINTER, 32'hc1, drs_pkg::RESP_OKAY);
        wr(drs_pkg::OFS_CTRL_POINTER, 32'hfe, drs_pkg::RESP_OKAY);
        foreach (w[i]) rd(drs_pkg::OFS_DATA_PORT, w[i], drs_pkg::RESP_OKAY);
        rd(drs_pkg::OFS_CTRL_POINTER, 32'hc1, drs_pkg::RESP_OKAY);
        wr(drs_pkg::OFS_CTRL_POINTER, 32'hff, drs_pkg::RESP_OKAY);
        rd(drs_pkg::OFS_DATA_PORT, w[1], drs_pkg::RESP_OKAY);
        wstrb <= 4'h1;
        wr(drs_pkg::OFS_CTRL_POINTER, 32'h1234_56c5, drs_pkg::RESP_OKAY);
        wstrb <= 4'hf;
        rd(drs_pkg::OFS_CTRL_POINTER, 32'hc5, drs_pkg::RESP_OKAY);
        $display("ram test done");
    endtask
    task automatic frame(input logic [23:0] px [3], input logic [7:0] idx,
                         output logic [31:0] sig);
        logic [23:0] c;
        c = drs_pkg::SIG_SEED;
        foreach (px[i]) begin
            @(posedge sys_clk);
            pixelData <= px[i]; pixelValid <= 1'b1; frameEnd <= (i == 2);
            c = crcStep(c, px[i]);
        end
        @(posedge sys_clk);
        pixelValid <= 1'b0; frameEnd <= 1'b0; pixelData <= ~pixelData;
        sig = {idx, c};
        rd(drs_pkg::OFS_SIGNATURE, sig, drs_pkg::RESP_OKAY);
    endtask
    task automatic testSig;
        logic [31:0] s;
        rd(drs_pkg::OFS_SIGNATURE, 32'h0, drs_pkg::RESP_OKAY);
        frame('{24'h123456, 24'habcdef, 24'h000001}, 8'h00, s);
        wr(drs_pkg::OFS_SIGNATURE, 32'hdead_beef, drs_pkg::RESP_OKAY);
        rd(drs_pkg::OFS_SIGNATURE, s, drs_pkg::RESP_OKAY);
        frame('{24'hff00ff, 24'h000000, 24'h800000}, 8'h01, s);
        $display("signature test done");
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        testGate();
        testRam();
        testSig();
        results();
    end
endmodule
`default_nettype wire
